// ### src/arb_pkg.sv
// shared constants and carrier types for the bus request arbiter
// assumes a single 10 MHz core clock and synchronous active-high reset
package arb_pkg;
  // ==========================================================
  // widths and counts
  localparam int          LINE_COUNT   = 4;    // request lines on the bus
  localparam int          INDEX_WIDTH  = 3;    // processor index straps
  localparam int          SLOT_WIDTH   = 2;    // line number within group
  // ==========================================================
  // index codes
  localparam logic [2:0]  INDEX_SOLO   = 3'h0; // single processor code
  localparam logic [2:0]  INDEX_FIRST  = 3'h1; // code that selects line 1
  localparam logic [2:0]  INDEX_LAST   = 3'h4; // highest legal code
  // ==========================================================
  // reset values
  localparam logic [3:0]  LINES_IDLE   = 4'hF; // all lines inactive high
  localparam logic [1:0]  SLOT_RESET   = 2'h0; // last owner at reset is line 1, so rotation starts at line 2

  // arbiter sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // not requesting
    ST_REQ  = 2'b01,  // request driven, waiting for grant
    ST_OWN  = 2'b10,  // owns the bus, access running
    ST_REL  = 2'b11   // releasing the line
  } arb_state_t;

  // straps caught after reset release
  typedef struct packed {
    logic [1:0] own_slot;  // own line number, 0 means line 1
    logic       rotating;  // rotating priority selected
    logic       pullup_en; // pull-ups on request and priority pins
    logic       solo;      // index code 000
  } strap_t;
endpackage : arb_pkg

// ### src/strap_sync.sv
// two-flop synchroniser for pin inputs of the arbiter
// assumes the pins are asynchronous to clk
`timescale 1ns/1ns
module strap_sync
  import arb_pkg::*;
#(
  parameter int WIDTH = 8  // number of pins synchronised
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // raw pins and their synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;  // first stage, read only by second
    logic [WIDTH-1:0] sync;  // second stage
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;

  // ==========================================================
  // next stage values
  always_comb begin
    next_state.meta = pin_in;
    next_state.sync = state.meta;
  end

  // stages run through reset on purpose: straps must be settled in the
  // second stage at release, so a reset value here would be caught as
  // the strap code; rst is kept only for a uniform port list
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign pin_sync = state.sync;
endmodule : strap_sync

// ### src/bus_request_arbiter.sv
// bus request arbitration for up to four processors on one bus
// assumes peers keep unused lines high and all share the priority strap
`timescale 1ns/1ns

// Overview of operation
// (R1) drive only own line, others are inputs
// (R2) watch every peer request line continuously
// (R3) unused lines held high by system
// (R4) own line never tied by system
// (R5) index 001 line 1, 010 line 2
// (R6) single processor uses index 000 or 001
// (R7) index codes 101 to 111 reserved
// (R8) index straps change only during reset
// (R9) priority strap high selects rotating priority
// (R10) priority strap low selects fixed priority
// (R11) same priority strap on every processor
// (R12) pull-ups enabled only when index 00x
// (R13) take bus when no higher request, release
module bus_request_arbiter
  import arb_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // configuration straps
  input  wire logic [INDEX_WIDTH-1:0] processor_index,
  input  wire logic                  priority_scheme_select,
  // request line pins, active low open style
  input  wire logic [LINE_COUNT-1:0] bus_request_line_n_in,
  output logic      [LINE_COUNT-1:0] bus_request_line_n_out,
  output logic      [LINE_COUNT-1:0] bus_request_line_n_oe,
  // core side
  input  wire logic                  access_req,
  input  wire logic                  access_done,
  output logic                       bus_granted,
  output logic      [LINE_COUNT-1:0] peer_requests,
  output logic                       pullup_en,
  output logic                       index_reserved
);
  // ==========================================================
  // state of the arbiter
  typedef struct packed {
    arb_state_t            fsm;       // sequencer state
    strap_t                strap;     // straps caught after reset
    logic                  caught;    // straps taken
    logic [SLOT_WIDTH-1:0] last_slot; // most recent bus owner
    logic [LINE_COUNT-1:0] peers;     // requesting peers
    logic                  granted;   // bus owned
    logic [LINE_COUNT-1:0] drive_n;   // pin output values
    logic [LINE_COUNT-1:0] drive_oe;  // pin enables
    logic                  reserved;  // illegal index code seen
  } arb_regs_t;
  arb_regs_t state;
  arb_regs_t next_state;

  logic [INDEX_WIDTH+LINE_COUNT:0] pins_sync;  // synchronised pins
  logic [LINE_COUNT-1:0]           req_seen;   // active-high requests
  logic [INDEX_WIDTH-1:0]          index_sync; // synchronised index
  logic                            prio_sync;  // synchronised strap

  // ==========================================================
  // pin synchroniser
  strap_sync #(
    .WIDTH (INDEX_WIDTH + LINE_COUNT + 1)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({processor_index, priority_scheme_select,
                bus_request_line_n_in}),
    .pin_sync (pins_sync)
  );
  assign index_sync = pins_sync[INDEX_WIDTH+LINE_COUNT:LINE_COUNT+1];
  assign prio_sync  = pins_sync[LINE_COUNT];
  assign req_seen   = ~pins_sync[LINE_COUNT-1:0];

  // (R5) index code to line number
  // map index code to line number; 000 shares line 1
  function automatic logic [SLOT_WIDTH-1:0] index_to_slot(
    input logic [INDEX_WIDTH-1:0] idx
  );
    logic [INDEX_WIDTH-1:0] tmp;
    tmp = (idx == INDEX_SOLO) ? INDEX_FIRST : idx;
    return SLOT_WIDTH'(tmp - INDEX_FIRST);
  endfunction : index_to_slot

  // true when some requester outranks own slot
  function automatic logic higher_pending(
    input logic [LINE_COUNT-1:0] reqs,
    input logic [SLOT_WIDTH-1:0] own,
    input logic                  rot,
    input logic [SLOT_WIDTH-1:0] last
  );
    logic [SLOT_WIDTH-1:0] first;
    logic [SLOT_WIDTH-1:0] pos;
    logic                  hit;
    first = rot ? SLOT_WIDTH'(last + 2'h1) : SLOT_RESET;
    hit   = 1'b0;
    for (int i = 0; i < LINE_COUNT; i++) begin
      pos = SLOT_WIDTH'(first + i[SLOT_WIDTH-1:0]);
      if (pos == own) begin
        break;
      end
      if (reqs[pos]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : higher_pending

  // ==========================================================
  // next state logic
  always_comb begin
    logic [LINE_COUNT-1:0] peer_mask;
    peer_mask  = '0;
    next_state = state;
    // (R8) straps taken once after reset
    if (!state.caught) begin
      next_state.caught          = 1'b1;
      next_state.strap.own_slot  = index_to_slot(index_sync);
      next_state.strap.solo      = (index_sync == INDEX_SOLO);
      // (R10) low strap keeps fixed priority
      next_state.strap.rotating  = prio_sync;
      // (R12) pull-ups only for index 00x
      next_state.strap.pullup_en = (index_sync[2:1] == 2'h0);
      next_state.reserved        = (index_sync > INDEX_LAST);
    end
    // (R2) peer lines watched every cycle
    peer_mask        = req_seen;
    peer_mask[state.strap.own_slot] = 1'b0;
    next_state.peers = peer_mask;
    // (R9) rotation follows the last owner seen
    // a peer whose request line drops has finished with the bus
    if (state.strap.rotating && !state.granted) begin
      for (int j = 0; j < LINE_COUNT; j++) begin
        if (state.peers[j] && !peer_mask[j]) begin
          next_state.last_slot = SLOT_WIDTH'(j);
        end
      end
    end
    case (state.fsm)
      ST_IDLE: begin
        if (state.caught && access_req && !state.reserved) begin
          next_state.fsm = ST_REQ;
        end
      end
      ST_REQ: begin
        // (R13) wait while a higher request is active
        if (!higher_pending(peer_mask, state.strap.own_slot,
                            state.strap.rotating, state.last_slot)) begin
          next_state.fsm     = ST_OWN;
          next_state.granted = 1'b1;
        end
      end
      ST_OWN: begin
        // (R13) release after the access completes
        if (access_done) begin
          next_state.fsm       = ST_REL;
          next_state.granted   = 1'b0;
          next_state.last_slot = state.strap.own_slot;
        end
      end
      ST_REL: begin
        next_state.fsm = ST_IDLE;
      end
      default: begin
        next_state.fsm = ST_IDLE;
      end
    endcase
    // (R1) drive only own line, low while requesting
    next_state.drive_oe = '0;
    next_state.drive_n  = LINES_IDLE;
    // enable follows the straps caught on this same edge
    if (next_state.caught) begin
      next_state.drive_oe[next_state.strap.own_slot] = 1'b1;
      next_state.drive_n[next_state.strap.own_slot] =
        !(next_state.fsm == ST_REQ || next_state.fsm == ST_OWN);
    end
  end

  // ==========================================================
  // state register; straps caught after release, never at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state           <= '0;
      state.fsm       <= ST_IDLE;
      state.drive_n   <= LINES_IDLE;
      state.last_slot <= SLOT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign bus_request_line_n_out = state.drive_n;
  assign bus_request_line_n_oe  = state.drive_oe;
  assign bus_granted            = state.granted;
  assign peer_requests          = state.peers;
  assign pullup_en              = state.strap.pullup_en;
  assign index_reserved         = state.reserved;

  // ==========================================================
  // checks
  // (R1) one enabled line only
  a_single_drive: assert property (@(posedge clk) disable iff (rst)
    $onehot0(bus_request_line_n_oe)) // (R1)
    else $error("more than one request line driven");
  // (R13) grant only after request phase
  a_grant_after_req: assert property (@(posedge clk) disable iff (rst)
    $rose(bus_granted) |-> $past(state.fsm) == ST_REQ) // (R13)
    else $error("grant without request");
  // (R13) line low while bus owned
  a_own_line_low: assert property (@(posedge clk) disable iff (rst)
    bus_granted |-> (bus_request_line_n_out | ~bus_request_line_n_oe)
      != LINES_IDLE) // (R13)
    else $error("bus owned with line released");
  // (R13) back in idle two cycles after done
  a_release_done: assert property (@(posedge clk) disable iff (rst)
    (bus_granted && access_done) |=> ##1 state.fsm == ST_IDLE) // (R13)
    else $error("no release after done");
  // (R2) own line never in peer set
  a_peer_excl_own: assert property (@(posedge clk) disable iff (rst)
    state.caught |-> !peer_requests[state.strap.own_slot]) // (R2)
    else $error("own line in peer set");
  // (R12) pull-up follows index
  a_pullup_index: assert property (@(posedge clk) disable iff (rst)
    state.caught |-> pullup_en == (state.strap.own_slot == 2'h0 &&
      !index_reserved)) // (R12)
    else $error("pull-up enable wrong");
  // (R10) fixed mode blocks on line 1
  a_fixed_block: assert property (@(posedge clk) disable iff (rst)
    (state.fsm == ST_REQ && !state.strap.rotating && req_seen[0] &&
      state.strap.own_slot != 2'h0) |=> !bus_granted) // (R10)
    else $error("fixed priority violated");
  // (R5) line one for index 000
  a_index_map: assert property (@(posedge clk) disable iff (rst)
    (state.caught && $stable(state.caught) && state.strap.solo)
      |-> state.strap.own_slot == 2'h0) // (R5)
    else $error("index map wrong");
  c_grant: cover property (@(posedge clk) disable iff (rst)
    $rose(bus_granted));
  c_wait: cover property (@(posedge clk) disable iff (rst)
    state.fsm == ST_REQ [*3]);
  c_rotating: cover property (@(posedge clk) disable iff (rst)
    state.strap.rotating && $rose(bus_granted));
endmodule : bus_request_arbiter

// ### verification/peer_model.sv
// peer processors sharing the request lines with the device under test
// assumes the bench commands which peer lines request the bus
`timescale 1ns/1ns
module peer_model
  import arb_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // commands from the bench
  input  wire logic [LINE_COUNT-1:0] want,
  input  wire logic                  slow,
  // device enables and peer pin drive
  input  wire logic [LINE_COUNT-1:0] dev_oe,
  output logic      [LINE_COUNT-1:0] peer_n
);
  // ==========================================================
  // peer pin drive
  logic [LINE_COUNT-1:0] want_d;  // extra stage models a slow peer

  // a released line reads high, same as the pull-up would give
  always_ff @(posedge clk) begin
    want_d <= want;
    // idle lines high, never the device line
    if (rst) begin
      peer_n <= LINES_IDLE;
    end else begin
      peer_n <= ~((slow ? want_d : want) & ~dev_oe);
    end
  end
endmodule : peer_model

// ### verification/multiproc_bus_request_arbitration_tb.sv
// self-checking bench for the bus request arbiter beside a peer model
// assumes a 100 ns clock and straps set only while reset is high
`timescale 1ns/1ns
module multiproc_bus_request_arbitration_tb import arb_pkg::*; ;
  // ==========================================================
  // signals
  logic                   clk, rst, rot, req, done, slow;
  logic [INDEX_WIDTH-1:0] idx;      // strapped processor index
  logic [LINE_COUNT-1:0]  line_in;  // resolved wire level
  logic [LINE_COUNT-1:0]  line_out, line_oe, peers, want, peer_n;
  logic                   granted, pu, rsvd;
  logic [3:0]             m;        // random peer pattern
  int                     err_total, check_count;

  // wire level: pull-up, then any driver pulling low wins
  assign line_in = (line_out | ~line_oe) & peer_n;

  bus_request_arbiter i_bus_request_arbiter (
    .clk(clk), .rst(rst), .processor_index(idx),
    .priority_scheme_select(rot), .bus_request_line_n_in(line_in),
    .bus_request_line_n_out(line_out), .bus_request_line_n_oe(line_oe),
    .access_req(req), .access_done(done), .bus_granted(granted),
    .peer_requests(peers), .pullup_en(pu), .index_reserved(rsvd));

  peer_model i_peer_model (
    .clk(clk), .rst(rst), .want(want), .slow(slow),
    .dev_oe(line_oe), .peer_n(peer_n));

  // ==========================================================
  // helpers
  function automatic logic [3:0] own_mask(input logic [2:0] i);
    return (i == INDEX_SOLO) ? 4'h1 : 4'h1 << (i - INDEX_FIRST);
  endfunction : own_mask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // straps change only inside reset, held 4 cycles
  task automatic start(input logic [2:0] i, input logic r);
    rst = 1'b1;
    req = 1'b0;
    done = 1'b0;
    want = 4'h0;
    slow = 1'b0;
    idx = i;
    rot = r;
    repeat (4) tick;
    rst = 1'b0;
    repeat (2) tick;
  endtask : start

  // a missing grant that was expected ends the run
  task automatic wait_grant(input int limit, input logic exp);
    int n;
    n = 0;
    while (granted !== 1'b1 && n < limit) begin
      tick;
      n++;
    end
    check({7'h0, granted}, {7'h0, exp});
    if (exp && granted !== 1'b1) complete_run;
  endtask : wait_grant

  task automatic finish_access;
    check({4'h0, line_out}, {4'h0, ~own_mask(idx)});
    req = 1'b0;
    done = 1'b1;
    tick;
    done = 1'b0;
    check({3'h0, granted, line_out}, {4'h0, LINES_IDLE});
    repeat (2) tick;
  endtask : finish_access

  // ==========================================================
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    err_total = 0;
    check_count = 0;
    start(3'h0, 1'b0);
    void'($urandom(32'h2178d17b));
    // every legal index, solo codes first
    for (int i = 0; i < 5; i++) begin
      start(i[2:0], 1'b0);
      check({4'h0, line_oe}, {4'h0, own_mask(idx)});
      check({6'h0, pu, rsvd}, {6'h0, idx[2:1] == 2'h0, 1'b0});
      req = 1'b1;
      wait_grant(4, 1'b1);
      finish_access;
      $display("test index %0d done", i);
    end
    // reserved codes left unused by the system
    for (int i = 5; i < 8; i++) begin
      start(i[2:0], 1'b0);
      req = 1'b1;
      wait_grant(10, 1'b0);
      check({3'h0, rsvd, line_out | ~line_oe}, 8'h1F);
      $display("test reserved %0d done", i);
    end
    // every peer line watched, random request patterns
    start(3'h2, 1'b0);
    for (int k = 0; k < 8; k++) begin
      m = 4'($urandom) & ~own_mask(idx);
      want = m;
      slow = m[0];
      repeat (5) tick;
      check({4'h0, peers & ~own_mask(idx)}, {4'h0, m});
    end
    slow = 1'b0;
    // higher line blocks, lower line does not
    want = 4'h1;
    repeat (4) tick;
    req = 1'b1;
    wait_grant(10, 1'b0);
    want = 4'h0;
    wait_grant(8, 1'b1);
    finish_access;
    want = 4'h8;
    repeat (4) tick;
    req = 1'b1;
    wait_grant(4, 1'b1);
    finish_access;
    $display("test fixed priority done");
    // after its own grant the device ranks last
    start(3'h2, 1'b1);
    req = 1'b1;
    wait_grant(4, 1'b1);
    finish_access;
    want = 4'h8;
    repeat (4) tick;
    req = 1'b1;
    wait_grant(10, 1'b0);
    want = 4'h0;
    wait_grant(8, 1'b1);
    finish_access;
    $display("test rotating priority done");
    complete_run;
  end
endmodule : multiproc_bus_request_arbitration_tb
